/* File: base_timer_pkg.sv */
package base_timer_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_COMMAND = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_COUNTER = 4'hC;
    // Control register fields.
    localparam int CTL_DIV_LSB = 0;
    localparam int CTL_PRE_BIT = 3;
    localparam int CTL_ALIGN_BIT = 4;
    localparam int CTL_SSHOT_BIT = 5;
    localparam int CTL_SRC_LSB = 6;
    localparam int CTL_START_LSB = 8;
    localparam int CTL_RUN_BIT = 16;
    localparam int CTL_DIR_BIT = 17;
    localparam int CTL_STE_BIT = 18;
    // Command register bits, write-only, read as zero.
    localparam int CMD_RUN_SET = 0;
    localparam int CMD_RUN_CLR = 1;
    localparam int CMD_CNT_CLR = 2;
    localparam int CMD_STE_SET = 3;
    localparam int CMD_STE_CLR = 4;
    localparam int CMD_STEP = 5;
    localparam int PRE_EXTRA_SHIFT = 8;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [15:0] ONE_VALUE = 16'h0001;
    typedef enum logic [1:0] {
        SRC_TIMER = 2'b00,
        SRC_SOFT = 2'b01,
        SRC_RISE = 2'b10,
        SRC_FALL = 2'b11
    } count_source_t;
    typedef enum logic [1:0] {
        START_NONE = 2'b00,
        START_RISE = 2'b01,
        START_FALL = 2'b10,
        START_BOTH = 2'b11
    } start_edge_t;
endpackage

/* File: count_tick_if.sv */
`timescale 1ns/1ps
interface count_tick_if;
    logic run_flag;
    logic [2:0] clock_divide_select;
    logic extra_prescale_enable;
    logic tick;
    modport source (input run_flag, input clock_divide_select, input extra_prescale_enable,
        output tick);
    modport sink (output run_flag, output clock_divide_select, output extra_prescale_enable,
        input tick);
endinterface

/* File: count_prescaler.sv */
`timescale 1ns/1ps
module count_prescaler (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    count_tick_if.source tk
);
    import base_timer_pkg::*;
    logic [14:0] div_count;
    logic [4:0] shift;
    logic [14:0] limit;
    logic at_limit;
    assign shift = {2'b00, tk.clock_divide_select}
        + (tk.extra_prescale_enable ? 5'(PRE_EXTRA_SHIFT) : 5'd0);
    assign limit = 15'((16'h0001 << shift) - 16'h0001);
    assign at_limit = (div_count == limit);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_count <= 15'h0000;
        end else if (!tk.run_flag || at_limit) begin
            div_count <= 15'h0000;
        end else begin
            div_count <= div_count + 15'h0001;
        end
    end
    assign tk.tick = tk.run_flag && at_limit;
endmodule

/* File: base_timer.sv */
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module base_timer #(
    parameter int CNT_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [base_timer_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic i_external_timer_input,
    input wire logic i_deadtime_idle,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_period_match,
    output logic o_zero_match,
    output logic o_one_match,
    output logic o_count_direction_flag,
    output logic o_run_flag,
    output logic o_shadow_transfer_strobe,
    output logic o_count_enable
);
    import base_timer_pkg::*;
    // Only a 16-bit counter is built, so any other width stops elaboration.
    if (CNT_W != 16) begin : g_width_check
        $error("base_timer supports a 16-bit counter only");
    end

    count_tick_if tk ();
    count_prescaler u_pre (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .tk(tk));

    logic [15:0] main_pwm_counter;
    logic [15:0] period_register;
    logic [15:0] period_shadow;
    logic [2:0] clock_divide_select;
    logic extra_prescale_enable;
    logic alignment_mode_bit;
    logic single_shot_bit;
    logic [1:0] count_source_select;
    logic [1:0] external_start_edge_select;
    logic run_flag;
    logic count_direction_flag;
    logic shadow_transfer_enable;
    logic ext_sync_a, ext_sync_b, ext_prev;

    assign tk.run_flag = run_flag;
    assign tk.clock_divide_select = clock_divide_select;
    assign tk.extra_prescale_enable = extra_prescale_enable;

    // Bus decode: one wait cycle; a write lands at the edge where waitrequest is low.
    wire access = (i_read || i_write) && o_waitrequest;
    wire wr = i_write && !o_waitrequest;
    wire wr_ctl = wr && (i_address == OFF_CONTROL);
    wire wr_cmd = wr && (i_address == OFF_COMMAND) && i_byteenable[0];
    wire wr_per = wr && (i_address == OFF_PERIOD);
    wire wr_cnt = wr && (i_address == OFF_COUNTER);
    wire cmd_run_set = wr_cmd && i_writedata[CMD_RUN_SET];
    wire cmd_run_clr = wr_cmd && i_writedata[CMD_RUN_CLR];
    wire cmd_cnt_clr = wr_cmd && i_writedata[CMD_CNT_CLR];
    wire cmd_ste_set = wr_cmd && i_writedata[CMD_STE_SET];
    wire cmd_ste_clr = wr_cmd && i_writedata[CMD_STE_CLR];
    wire cmd_step = wr_cmd && i_writedata[CMD_STEP];

    wire ext_rise = ext_sync_b && !ext_prev;
    wire ext_fall = !ext_sync_b && ext_prev;

    logic src_tick;
    always_comb begin
        unique case (count_source_t'(count_source_select))
            SRC_TIMER: src_tick = tk.tick;
            SRC_SOFT: src_tick = run_flag && cmd_step;
            SRC_RISE: src_tick = run_flag && ext_rise;
            SRC_FALL: src_tick = run_flag && ext_fall;
        endcase
    end
    wire step = src_tick;

    logic ext_start;
    always_comb begin
        unique case (start_edge_t'(external_start_edge_select))
            START_NONE: ext_start = 1'b0;
            START_RISE: ext_start = ext_rise;
            START_FALL: ext_start = ext_fall;
            START_BOTH: ext_start = ext_rise || ext_fall;
        endcase
    end

    wire pm = (main_pwm_counter == period_register);
    wire zm = (main_pwm_counter == 16'h0000);
    wire om = (main_pwm_counter == ONE_VALUE);

    // Edge mode wraps after the period; center mode steps by direction.
    // A direction left over from center mode must not make edge mode count down.
    wire [15:0] next_counter = (!alignment_mode_bit && pm) ? 16'h0000 :
        ((alignment_mode_bit && count_direction_flag) ? main_pwm_counter - 16'h0001 :
        main_pwm_counter + 16'h0001);
    wire next_dir = !alignment_mode_bit ? 1'b0 :
        (!count_direction_flag && pm) ? 1'b1 :
        (count_direction_flag && om) ? 1'b0 : count_direction_flag;
    // Period end: edge wrap, or center count-down reaching zero.
    wire period_end = step && (alignment_mode_bit ?
        (count_direction_flag && om) : pm);
    // Transfer fires at period end or while stopped, only when enabled.
    wire st = shadow_transfer_enable && (period_end || !run_flag);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_sync_a <= 1'b0;
            ext_sync_b <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync_a <= i_external_timer_input;
            ext_sync_b <= ext_sync_a;
            ext_prev <= ext_sync_b;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clock_divide_select <= 3'b000;
            extra_prescale_enable <= 1'b0;
            alignment_mode_bit <= 1'b0;
            single_shot_bit <= 1'b0;
            count_source_select <= 2'b00;
            external_start_edge_select <= 2'b00;
        end else begin
            if (wr_ctl && i_byteenable[0]) begin
                clock_divide_select <= i_writedata[CTL_DIV_LSB +: 3];
                extra_prescale_enable <= i_writedata[CTL_PRE_BIT];
                alignment_mode_bit <= i_writedata[CTL_ALIGN_BIT];
                single_shot_bit <= i_writedata[CTL_SSHOT_BIT];
                count_source_select <= i_writedata[CTL_SRC_LSB +: 2];
            end
            if (wr_ctl && i_byteenable[1]) begin
                external_start_edge_select <= i_writedata[CTL_START_LSB +: 2];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_flag <= 1'b0;
        end else if (cmd_run_set || ext_start) begin
            run_flag <= 1'b1;
        end else if (cmd_run_clr || (single_shot_bit && period_end)) begin
            run_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shadow_transfer_enable <= 1'b0;
        end else if (cmd_ste_set) begin
            shadow_transfer_enable <= 1'b1;
        end else if (cmd_ste_clr || st) begin
            shadow_transfer_enable <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_shadow <= PERIOD_RESET;
            period_register <= PERIOD_RESET;
        end else begin
            if (wr_per) begin
                period_shadow <= i_writedata[15:0];
            end
            if (st) begin
                period_register <= period_shadow;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            main_pwm_counter <= 16'h0000;
            count_direction_flag <= 1'b0;
        end else if (cmd_cnt_clr) begin
            main_pwm_counter <= 16'h0000;
        end else if (wr_cnt && !run_flag && i_deadtime_idle) begin
            main_pwm_counter <= i_writedata[15:0];
        end else if (step) begin
            main_pwm_counter <= next_counter;
            count_direction_flag <= next_dir;
        end else if (!alignment_mode_bit) begin
            count_direction_flag <= 1'b0;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (i_address)
            OFF_CONTROL: begin
                rd_mux[CTL_DIV_LSB +: 3] = clock_divide_select;
                rd_mux[CTL_PRE_BIT] = extra_prescale_enable;
                rd_mux[CTL_ALIGN_BIT] = alignment_mode_bit;
                rd_mux[CTL_SSHOT_BIT] = single_shot_bit;
                rd_mux[CTL_SRC_LSB +: 2] = count_source_select;
                rd_mux[CTL_START_LSB +: 2] = external_start_edge_select;
                rd_mux[CTL_RUN_BIT] = run_flag;
                rd_mux[CTL_DIR_BIT] = count_direction_flag;
                rd_mux[CTL_STE_BIT] = shadow_transfer_enable;
            end
            OFF_PERIOD: rd_mux[15:0] = period_register;
            OFF_COUNTER: rd_mux[15:0] = main_pwm_counter;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h00000000;
        end else begin
            o_waitrequest <= !access;
            if (access && i_read) begin
                o_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_period_match <= 1'b0;
            o_zero_match <= 1'b1;
            o_one_match <= 1'b0;
            o_count_direction_flag <= 1'b0;
            o_run_flag <= 1'b0;
            o_shadow_transfer_strobe <= 1'b0;
            o_count_enable <= 1'b0;
        end else begin
            o_period_match <= pm;
            o_zero_match <= zm;
            o_one_match <= om;
            o_count_direction_flag <= count_direction_flag;
            o_run_flag <= run_flag;
            o_shadow_transfer_strobe <= st;
            o_count_enable <= step;
        end
    end
endmodule

/* File: base_timer_chk.sv */
`timescale 1ns/1ps
module base_timer_chk #(
    parameter int CNT_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [base_timer_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic i_external_timer_input,
    input wire logic i_deadtime_idle,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic o_period_match,
    input wire logic o_zero_match,
    input wire logic o_one_match,
    input wire logic o_count_direction_flag,
    input wire logic o_run_flag,
    input wire logic o_shadow_transfer_strobe,
    input wire logic o_count_enable
);
    import base_timer_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_taken;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_answer;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    sequence s_run_set;
        s_taken ##0 i_write && i_address == OFF_COMMAND && i_byteenable[0] && i_writedata[0];
    endsequence
    property p_wait;
        s_taken |=> s_answer;
    endproperty
    a_wait: assert property (p_wait) else $error("access did not answer after one wait state");
    property p_rd_hold;
        $changed(o_readdata) |-> $past(i_read && o_waitrequest);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
    property p_wo_zero;
        i_read && o_waitrequest && (i_address == OFF_COMMAND || i_address[1:0] != 2'b00)
            |=> o_readdata == 32'h00000000;
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("write-only place read nonzero");
    property p_run_set;
        s_run_set |-> ##[2:3] o_run_flag;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run set command ignored");
    property p_dir_rise;
        $rose(o_count_direction_flag) |-> $past(o_period_match);
    endproperty
    a_dir_rise: assert property (p_dir_rise) else $error("turned down without period match");
    property p_zero_one;
        !(o_zero_match && o_one_match);
    endproperty
    a_zero_one: assert property (p_zero_one) else $error("zero and one match together");
    property p_ce_run;
        o_count_enable |-> o_run_flag;
    endproperty
    a_ce_run: assert property (p_ce_run) else $error("count step while stopped");
    property p_strobe;
        o_shadow_transfer_strobe |=> !o_shadow_transfer_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("transfer strobe longer than a cycle");
endmodule

bind base_timer base_timer_chk #(.CNT_W(CNT_W)) base_timer_chk_i (.*);

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import base_timer_pkg::*;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [ADDR_W-1:0] i_address = '0;
    logic [31:0] i_writedata = '0, o_readdata, q;
    logic [3:0] i_byteenable = 4'hF;
    logic i_external_timer_input = 1'b0, i_deadtime_idle = 1'b1;
    logic o_waitrequest, o_period_match, o_zero_match, o_one_match, o_count_direction_flag;
    logic o_run_flag, o_shadow_transfer_strobe, o_count_enable;
    int num_errors = 0, n_tests = 0, seed = 32'h7D5F, n, t0, t1;
    logic [16:0] st;
    logic [15:0] per;
    base_timer base_timer_i (.*);
    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge i_core_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 100);
        if (o_waitrequest !== 1'b0) begin
            num_errors++;
            conclude();
        end
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic cmd(input int b);
        bus(1'b1, OFF_COMMAND, 32'h1 << b);
    endtask
    task automatic to_pulse(output int c);
        c = 0;
        do begin
            @(negedge i_core_clk);
            c++;
        end while (o_count_enable !== 1'b1 && c < 1000);
        if (c >= 1000) begin
            num_errors++;
            conclude();
        end
    endtask
    function automatic logic [16:0] nxt(input logic [16:0] s, input logic [15:0] p, input logic c);
        if (!c) return {1'b0, (s[15:0] == p) ? 16'h0000 : s[15:0] + 16'h0001};
        return {s[16] ? s[15:0] != ONE_VALUE : s[15:0] == p,
            s[16] ? s[15:0] - 16'h0001 : s[15:0] + 16'h0001};
    endfunction
    function automatic logic [31:0] ctl(input int dv, pre, al, ss, src, stt);
        return (dv << CTL_DIV_LSB) | (pre << CTL_PRE_BIT) | (al << CTL_ALIGN_BIT)
            | (ss << CTL_SSHOT_BIT) | (src << CTL_SRC_LSB) | (stt << CTL_START_LSB);
    endfunction
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(negedge i_core_clk);
        chk("zero_match", 1, o_zero_match);
        bus(0, 4'h2, 0);
        chk("unmapped", 0, q);
        per = 16'h0003 + 16'($random(seed) & 7);
        bus(1, OFF_PERIOD, per);
        bus(0, OFF_PERIOD, 0);
        chk("period_active", PERIOD_RESET, q);
        cmd(CMD_STE_SET);
        repeat (2) @(negedge i_core_clk);
        chk("strobe", 1, o_shadow_transfer_strobe);
        @(negedge i_core_clk);
        chk("strobe_end", 0, o_shadow_transfer_strobe);
        bus(0, OFF_PERIOD, 0);
        chk("period_moved", per, q);
        bus(0, OFF_COMMAND, 0);
        chk("command_read", 0, q);
        bus(1, OFF_COUNTER, 5);
        bus(0, OFF_COUNTER, 0);
        chk("cnt_write", 5, q);
        i_deadtime_idle <= 1'b0;
        bus(1, OFF_COUNTER, 7);
        i_deadtime_idle <= 1'b1;
        bus(0, OFF_COUNTER, 0);
        chk("cnt_dead", 5, q);
        for (int al = 0; al < 2; al++) begin
            bus(1, OFF_CONTROL, ctl(0, 0, al, 0, SRC_SOFT, START_NONE));
            cmd(CMD_CNT_CLR);
            cmd(CMD_RUN_SET);
            st = '0;
            repeat (8) begin
                n = 1 + ($random(seed) & 3);
                repeat (n) cmd(CMD_STEP);
                repeat (n) st = nxt(st, per, al[0]);
                bus(0, OFF_COUNTER, 0);
                chk("count", st[15:0], q);
                chk("dir", st[16], o_count_direction_flag);
                chk("match", {st[15:0] == per, st[15:0] == 0, st[15:0] == 1},
                    {o_period_match, o_zero_match, o_one_match});
            end
            bus(1, OFF_COUNTER, 9);
            bus(0, OFF_COUNTER, 0);
            chk("cnt_running", st[15:0], q);
            cmd(CMD_CNT_CLR);
            bus(0, OFF_COUNTER, 0);
            chk("cnt_clear", 0, q);
            chk("still_run", 1, o_run_flag);
            cmd(CMD_RUN_CLR);
        end
        bus(1, OFF_CONTROL, ctl(0, 0, 0, 1, SRC_SOFT, START_NONE));
        cmd(CMD_RUN_SET);
        repeat (per) cmd(CMD_STEP);
        chk("shot_mid", 1, o_run_flag);
        cmd(CMD_STEP);
        repeat (3) @(negedge i_core_clk);
        chk("shot_end", 0, o_run_flag);
        for (int s = 2; s < 4; s++) begin
            bus(1, OFF_CONTROL, ctl(0, 0, 0, 0, s, START_NONE));
            cmd(CMD_CNT_CLR);
            cmd(CMD_RUN_SET);
            n = 2 + ($random(seed) & 1);
            repeat (n) begin
                repeat (4) @(posedge i_core_clk);
                i_external_timer_input <= 1'b1;
                repeat (4) @(posedge i_core_clk);
                i_external_timer_input <= 1'b0;
            end
            repeat (6) @(posedge i_core_clk);
            bus(0, OFF_COUNTER, 0);
            chk("edge_count", n, q);
            cmd(CMD_RUN_CLR);
        end
        bus(1, OFF_CONTROL, ctl(7, 1, 0, 0, SRC_TIMER, START_RISE));
        i_external_timer_input <= 1'b1;
        repeat (8) @(negedge i_core_clk);
        chk("ext_start", 1, o_run_flag);
        i_external_timer_input <= 1'b0;
        cmd(CMD_RUN_CLR);
        repeat (2) @(negedge i_core_clk);
        chk("sw_stop", 0, o_run_flag);
        for (int d = 0; d < 9; d++) begin
            bus(1, OFF_CONTROL, ctl(d % 8, d / 8, 0, 0, SRC_TIMER, START_NONE));
            for (int r = 0; r < 2; r++) begin
                cmd(CMD_RUN_SET);
                to_pulse(t0);
                to_pulse(t1);
                chk("spacing", 1 << (d % 8 + 8 * (d / 8)), t1);
                if (r == 1) chk("start_delay", n, t0);
                n = t0;
                cmd(CMD_RUN_CLR);
                repeat ($random(seed) & 7) @(posedge i_core_clk);
            end
        end
        conclude();
    end
endmodule
